// ===== rtl/rsx_exec.sv
`timescale 1ns/100ps


// ============================================================================
// execute unit with watchdog and axi4-lite status/control
module rsx_exec
  import rsx_pkg::*;
#(
  parameter logic [DATA_W-1:0] DIV_TERM_RST = RST_DIV_TERM
)(
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // decoder request
  input  wire logic                  op_valid,
  input  wire rsx_op_t               op_code,
  input  wire logic [ADDR_W-1:0]     op_reg_addr,
  input  wire logic                  op_dest,
  input  wire logic [DATA_W-1:0]     op_imm,
  input  wire logic [AUX_IDX_W-1:0]  op_aux_idx,
  // data memory
  input  wire logic [DATA_W-1:0]     dmem_rdata,
  output logic                       dmem_we,
  output logic [ADDR_W-1:0]          dmem_waddr,
  output logic [DATA_W-1:0]          dmem_wdata,
  // core state
  output logic                       op_done,
  output logic [DATA_W-1:0]          acc,
  output logic                       carry,
  output logic                       digit_carry,
  output logic                       zero,
  output logic                       watchdog_expiry_flag,
  output logic                       powerdown_flag,
  output logic                       halted,
  // axi4-lite write
  input  wire logic [AXI_AW-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [AXI_DW-1:0]     s_axi_wdata,
  input  wire logic [AXI_DW/8-1:0]   s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // axi4-lite read
  input  wire logic [AXI_AW-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [AXI_DW-1:0]          s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  // ==========================================================================
  // state
  rsx_mode_t           mode_ff;
  logic [DATA_W-1:0]   acc_ff;
  logic                carry_ff;
  logic                dc_ff;
  logic                zero_ff;
  logic                expiry_ff;
  logic                pdown_ff;
  logic                dmem_we_ff;
  logic [ADDR_W-1:0]   dmem_waddr_ff;
  logic [DATA_W-1:0]   dmem_wdata_ff;
  logic                done_ff;
  logic                wdt_en_ff;
  logic [DATA_W-1:0]   div_term_ff;
  logic [DATA_W-1:0]   div_cnt_ff;
  logic [DATA_W-1:0]   wdt_cnt_ff;
  logic                awready_ff;
  logic                wready_ff;
  logic                aw_got_ff;
  logic                w_got_ff;
  logic [AXI_AW-1:0]   awaddr_ff;
  logic [AXI_DW-1:0]   wdata_ff;
  logic [AXI_DW/8-1:0] wstrb_ff;
  logic                bvalid_ff;
  logic [1:0]          bresp_ff;
  logic                arready_ff;
  logic                rvalid_ff;
  logic [AXI_DW-1:0]   rdata_ff;
  logic [1:0]          rresp_ff;

  logic                exec;
  logic                is_halt_op;
  logic                aw_hs;
  logic                w_hs;
  logic                wr_fire;
  logic                ar_hs;
  logic                wake_req;
  logic                div_tick;
  logic                wdt_wrap;
  logic [AXI_DW-1:0]   nxt_rdata;
  logic [1:0]          nxt_rresp;

  rsx_core_if core ();

  // ==========================================================================
  // datapath instances
  rsx_alu u_alu (
    .core (core.alu_mp)
  );

  rsx_aux_page #(
    .DEPTH (AUX_DEPTH)
  ) u_aux (
    .aclk    (aclk),
    .aresetn (aresetn),
    .core    (core.aux_mp)
  );

  // requests are dropped while halted; the decoder sees no done pulse
  assign exec       = op_valid && (mode_ff == RSX_MODE_RUN);
  assign is_halt_op = exec && (op_code == RSX_OP_HALT_ENTRY);

  // operand is the data-memory byte or the immediate
  always_comb begin
    core.op        = op_code;
    core.acc       = acc_ff;
    core.cin       = carry_ff;
    core.operand   = (op_code == RSX_OP_SUB_BORROW_I) ? op_imm
                                                      : dmem_rdata;
    core.aux_idx   = op_aux_idx;
    core.aux_wdata = acc_ff;
    core.aux_we    = exec && (op_code == RSX_OP_AUX_WRITE);
  end

  // ==========================================================================
  // accumulator and arithmetic flags, all settled in one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_ff   <= RST_ACC;
      carry_ff <= 1'b0;
      dc_ff    <= 1'b0;
      zero_ff  <= 1'b0;
    end else if (exec) begin
      unique case (op_code)
        RSX_OP_ROT_RIGHT: begin
          carry_ff <= core.cout;
          if (op_dest == DEST_ACC) begin
            acc_ff <= core.result;
          end
        end
        RSX_OP_SUB_BORROW_R: begin
          carry_ff <= core.cout;
          dc_ff    <= core.dcout;
          zero_ff  <= core.zout;
          if (op_dest == DEST_ACC) begin
            acc_ff <= core.result;
          end
        end
        RSX_OP_SUB_BORROW_I: begin
          acc_ff   <= core.result;
          carry_ff <= core.cout;
          dc_ff    <= core.dcout;
          zero_ff  <= core.zout;
        end
        RSX_OP_AUX_READ: begin
          acc_ff <= core.aux_rdata;
        end
        RSX_OP_AUX_WRITE,
        RSX_OP_HALT_ENTRY,
        RSX_OP_NONE: begin
          // accumulator and flags untouched
        end
        default: begin
          // undefined codes are ignored
        end
      endcase
    end
  end

  // write-back to the addressed data-memory byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dmem_we_ff    <= 1'b0;
      dmem_waddr_ff <= {ADDR_W{1'b0}};
      dmem_wdata_ff <= RST_ACC;
    end else begin
      dmem_we_ff    <= exec && (op_dest == DEST_REG)
                       && (op_code == RSX_OP_ROT_RIGHT
                       ||  op_code == RSX_OP_SUB_BORROW_R);
      dmem_waddr_ff <= op_reg_addr;
      dmem_wdata_ff <= core.result;
    end
  end

  // completion pulse, one per accepted instruction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= exec;
    end
  end

  // ==========================================================================
  // run/halt mode; only software wakes the core here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= RSX_MODE_RUN;
    end else if (is_halt_op) begin
      mode_ff <= RSX_MODE_HALT;
    end else if (wake_req) begin
      mode_ff <= RSX_MODE_RUN;
    end
  end

  // status flags; both read as one after power-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      expiry_ff <= RST_FLAG_HI;
      pdown_ff  <= RST_FLAG_HI;
    end else if (is_halt_op) begin
      expiry_ff <= 1'b1;
      pdown_ff  <= 1'b0;
    end else if (wdt_wrap) begin
      expiry_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // watchdog divider and counter; halt entry restarts both from zero
  assign div_tick = wdt_en_ff && (div_cnt_ff == div_term_ff);
  assign wdt_wrap = div_tick && (wdt_cnt_ff == WDT_TOP);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_ff <= WDT_CLEAR;
    end else if (is_halt_op || div_tick) begin
      div_cnt_ff <= WDT_CLEAR;
    end else if (wdt_en_ff) begin
      div_cnt_ff <= div_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_cnt_ff <= WDT_CLEAR;
    end else if (is_halt_op) begin
      wdt_cnt_ff <= WDT_CLEAR;
    end else if (div_tick) begin
      wdt_cnt_ff <= wdt_cnt_ff + 8'h01;  // wraps, expiry flag records it
    end
  end

  // ==========================================================================
  // axi4-lite write path: address and data in either order
  assign aw_hs   = s_axi_awvalid && awready_ff;
  assign w_hs    = s_axi_wvalid && wready_ff;
  assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wake_req = wr_fire && (awaddr_ff == OFS_WAKE)
                    && wstrb_ff[0] && wdata_ff[WAKE_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff  <= 1'b0;
      awaddr_ff  <= {AXI_AW{1'b0}};
      awready_ff <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_got_ff <= 1'b0;
      end
      awready_ff <= !(aw_hs || (aw_got_ff && !wr_fire));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_ff  <= 1'b0;
      wdata_ff  <= {AXI_DW{1'b0}};
      wstrb_ff  <= {(AXI_DW/8){1'b0}};
      wready_ff <= 1'b0;
    end else begin
      if (w_hs) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_got_ff <= 1'b0;
      end
      wready_ff <= !(w_hs || (w_got_ff && !wr_fire));
    end
  end

  // response follows both halves; read-only writes are accepted silently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      unique case (awaddr_ff)
        OFS_STATUS, OFS_WDT_CTRL, OFS_WDT_CNT, OFS_WAKE: begin
          bresp_ff <= RESP_OKAY;
        end
        default: begin
          bresp_ff <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // watchdog control, byte lanes honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_en_ff   <= 1'b0;
      div_term_ff <= DIV_TERM_RST;
    end else if (wr_fire && awaddr_ff == OFS_WDT_CTRL) begin
      if (wstrb_ff[0]) begin
        wdt_en_ff <= wdata_ff[WCTRL_EN];
      end
      if (wstrb_ff[1]) begin
        div_term_ff <= wdata_ff[WCTRL_DIV_LSB +: DATA_W];
      end
    end
  end

  // ==========================================================================
  // axi4-lite read path, answer one cycle after the address is taken
  assign ar_hs = s_axi_arvalid && arready_ff;

  always_comb begin
    nxt_rdata = {AXI_DW{1'b0}};
    nxt_rresp = RESP_OKAY;
    unique case (s_axi_araddr)
      OFS_STATUS: begin
        nxt_rdata[ST_ACC_LSB +: DATA_W] = acc_ff;
        nxt_rdata[ST_CARRY]  = carry_ff;
        nxt_rdata[ST_DC]     = dc_ff;
        nxt_rdata[ST_ZERO]   = zero_ff;
        nxt_rdata[ST_EXPIRY] = expiry_ff;
        nxt_rdata[ST_PDOWN]  = pdown_ff;
        nxt_rdata[ST_HALT]   = (mode_ff == RSX_MODE_HALT);
      end
      OFS_WDT_CTRL: begin
        nxt_rdata[WCTRL_EN] = wdt_en_ff;
        nxt_rdata[WCTRL_DIV_LSB +: DATA_W] = div_term_ff;
      end
      OFS_WDT_CNT: begin
        nxt_rdata[WCNT_CNT_LSB +: DATA_W] = wdt_cnt_ff;
        nxt_rdata[WCNT_DIV_LSB +: DATA_W] = div_cnt_ff;
      end
      OFS_WAKE: begin
        // write-only strobe, reads zero
      end
      default: begin
        nxt_rresp = RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff  <= 1'b0;
      rdata_ff   <= {AXI_DW{1'b0}};
      rresp_ff   <= RESP_OKAY;
      arready_ff <= 1'b0;
    end else begin
      if (ar_hs) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= nxt_rdata;
        rresp_ff  <= nxt_rresp;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
      arready_ff <= !(ar_hs || (rvalid_ff && !s_axi_rready));
    end
  end

  // ==========================================================================
  // outputs straight from flip-flops
  assign dmem_we              = dmem_we_ff;
  assign dmem_waddr           = dmem_waddr_ff;
  assign dmem_wdata           = dmem_wdata_ff;
  assign op_done              = done_ff;
  assign acc                  = acc_ff;
  assign carry                = carry_ff;
  assign digit_carry          = dc_ff;
  assign zero                 = zero_ff;
  assign watchdog_expiry_flag = expiry_ff;
  assign powerdown_flag       = pdown_ff;
  assign halted               = mode_ff;
  assign s_axi_awready        = awready_ff;
  assign s_axi_wready         = wready_ff;
  assign s_axi_bvalid         = bvalid_ff;
  assign s_axi_bresp          = bresp_ff;
  assign s_axi_arready        = arready_ff;
  assign s_axi_rvalid         = rvalid_ff;
  assign s_axi_rdata          = rdata_ff;
  assign s_axi_rresp          = rresp_ff;

endmodule

// ===== rtl/rsx_pkg.sv
package rsx_pkg;

  // ==========================================================================
  // datapath widths
  localparam int DATA_W    = 8;
  localparam int NIB_W     = 4;
  localparam int ADDR_W    = 6;
  localparam int AUX_IDX_W = 4;
  localparam int AUX_DEPTH = 16;
  localparam int AXI_AW    = 12;
  localparam int AXI_DW    = 32;

  // ==========================================================================
  // instruction codes handed over by the decoder
  typedef enum logic [2:0] {
    RSX_OP_NONE          = 3'b000,  // any instruction outside this subset
    RSX_OP_ROT_RIGHT     = 3'b001,  // rotate_right_thru_carry
    RSX_OP_SUB_BORROW_R  = 3'b010,  // sub_with_borrow_reg
    RSX_OP_SUB_BORROW_I  = 3'b011,  // sub_with_borrow_imm
    RSX_OP_AUX_READ      = 3'b100,  // aux_page_read
    RSX_OP_AUX_WRITE     = 3'b101,  // aux_page_write
    RSX_OP_HALT_ENTRY    = 3'b110   // halt entry
  } rsx_op_t;

  // core run state
  typedef enum logic [0:0] {
    RSX_MODE_RUN  = 1'b0,
    RSX_MODE_HALT = 1'b1
  } rsx_mode_t;

  // destination selector values
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_REG = 1'b1;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [AXI_AW-1:0] OFS_STATUS   = 12'h000;
  localparam logic [AXI_AW-1:0] OFS_WDT_CTRL = 12'h004;
  localparam logic [AXI_AW-1:0] OFS_WDT_CNT  = 12'h008;
  localparam logic [AXI_AW-1:0] OFS_WAKE     = 12'h00C;

  // status register fields
  localparam int ST_ACC_LSB = 0;
  localparam int ST_CARRY   = 8;
  localparam int ST_DC      = 9;
  localparam int ST_ZERO    = 10;
  localparam int ST_EXPIRY  = 11;
  localparam int ST_PDOWN   = 12;
  localparam int ST_HALT    = 13;

  // watchdog control / count fields
  localparam int WCTRL_EN      = 0;
  localparam int WCTRL_DIV_LSB = 8;
  localparam int WCNT_CNT_LSB  = 0;
  localparam int WCNT_DIV_LSB  = 8;
  localparam int WAKE_BIT      = 0;

  // ==========================================================================
  // reset values
  localparam logic [DATA_W-1:0] RST_ACC      = 8'h00;
  localparam logic [DATA_W-1:0] RST_DIV_TERM = 8'h07;
  localparam logic [DATA_W-1:0] WDT_CLEAR    = 8'h00;
  localparam logic [DATA_W-1:0] WDT_TOP      = 8'hFF;
  localparam logic              RST_FLAG_HI  = 1'b1;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ===== rtl/rsx_core_if.sv
`timescale 1ns/100ps

// ============================================================================
// carrier between the execute unit, its adder and the auxiliary page
interface rsx_core_if;
  import rsx_pkg::*;

  // arithmetic unit
  rsx_op_t           op;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] acc;
  logic              cin;
  logic [DATA_W-1:0] result;
  logic              cout;
  logic              dcout;
  logic              zout;

  // auxiliary page
  logic                 aux_we;
  logic [AUX_IDX_W-1:0] aux_idx;
  logic [DATA_W-1:0]    aux_wdata;
  logic [DATA_W-1:0]    aux_rdata;

  modport exec_mp (output op, operand, acc, cin, aux_we, aux_idx, aux_wdata,
                   input  result, cout, dcout, zout, aux_rdata);
  modport alu_mp  (input  op, operand, acc, cin,
                   output result, cout, dcout, zout);
  modport aux_mp  (input  aux_we, aux_idx, aux_wdata,
                   output aux_rdata);
endinterface

// ===== rtl/rsx_alu.sv
`timescale 1ns/100ps

// ============================================================================
// combinational result and flag generation
module rsx_alu
  import rsx_pkg::*;
(
  // carrier
  rsx_core_if.alu_mp core
);

  logic [DATA_W:0]  sum9;
  logic [NIB_W:0]   sum5;

  // subtract as add of the inverted accumulator plus carry
  always_comb begin
    sum9        = {1'b0, core.operand} + {1'b0, ~core.acc}
                  + {{DATA_W{1'b0}}, core.cin};
    sum5        = {1'b0, core.operand[NIB_W-1:0]}
                  + {1'b0, ~core.acc[NIB_W-1:0]}
                  + {{NIB_W{1'b0}}, core.cin};
    core.result = sum9[DATA_W-1:0];
    core.cout   = sum9[DATA_W];
    core.dcout  = sum5[NIB_W];
    unique case (core.op)
      RSX_OP_ROT_RIGHT: begin
        core.result = {core.cin, core.operand[DATA_W-1:1]};
        core.cout   = core.operand[0];
        core.dcout  = 1'b0;
      end
      RSX_OP_AUX_READ,
      RSX_OP_AUX_WRITE,
      RSX_OP_HALT_ENTRY,
      RSX_OP_NONE: begin
        core.result = core.operand;
        core.cout   = core.cin;
        core.dcout  = 1'b0;
      end
      default: begin
        // both borrow forms share the adder; the operand picks the source
      end
    endcase
    core.zout = (core.result == {DATA_W{1'b0}});
  end

endmodule

// ===== rtl/rsx_aux_page.sv
`timescale 1ns/100ps

// ============================================================================
// sixteen auxiliary special-function registers
module rsx_aux_page
  import rsx_pkg::*;
#(
  parameter int DEPTH = AUX_DEPTH
)(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // carrier
  rsx_core_if.aux_mp core
);

  logic [DATA_W-1:0] page_ff [DEPTH];

  // one write port, written at the end of the executing cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        page_ff[i] <= RST_ACC;
      end
    end else if (core.aux_we) begin
      page_ff[core.aux_idx] <= core.aux_wdata;
    end
  end

  // asynchronous read; a read never disturbs the entry
  assign core.aux_rdata = page_ff[core.aux_idx];

endmodule

// ===== verif/rsx_exec_checker.sv
`timescale 1ns/100ps

// ============================================================================
// port checker for the execute unit
module rsx_exec_checker
  import rsx_pkg::*;
(
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // decoder request
  input wire logic       op_valid,
  input wire rsx_op_t    op_code,
  input wire logic [5:0] op_reg_addr,
  input wire logic       op_dest,
  input wire logic [7:0] op_imm,
  // data memory
  input wire logic [7:0] dmem_rdata,
  input wire logic       dmem_we,
  input wire logic [5:0] dmem_waddr,
  input wire logic [7:0] dmem_wdata,
  // core state
  input wire logic       op_done,
  input wire logic [7:0] acc,
  input wire logic       carry,
  input wire logic       zero,
  input wire logic       watchdog_expiry_flag,
  input wire logic       powerdown_flag,
  input wire logic       halted
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // accepted op by kind; a halted core takes nothing
  wire logic go  = op_valid && !halted;
  wire logic rot = go && op_code == RSX_OP_ROT_RIGHT;
  wire logic sbr = go && op_code == RSX_OP_SUB_BORROW_R;
  wire logic sbi = go && op_code == RSX_OP_SUB_BORROW_I;
  // register-form result shows on the write-back bus, else in acc
  wire logic [7:0] res = dmem_we ? dmem_wdata : acc;

  // ==========================================================================
  // assertions
  AST_DONE: assert property (go |=> op_done)
    else $error("missing completion pulse");
  AST_IDLE: assert property (!go |=> !op_done)
    else $error("completion without accepted op");
  AST_ROT: assert property (rot |=> carry == $past(dmem_rdata[0])
    && res == {$past(carry), $past(dmem_rdata[7:1])})
    else $error("rotate result wrong");
  AST_DEST: assert property ((rot || sbr) |=>
    dmem_we == $past(op_dest) && (!dmem_we || dmem_waddr == $past(op_reg_addr)))
    else $error("destination routing wrong");
  AST_SUBR: assert property (sbr |=> {carry, res} ==
    9'($past(dmem_rdata)) + {1'b0, ~$past(acc)} + 9'($past(carry))
    && zero == (res == 8'h00))
    else $error("register subtract wrong");
  AST_SUBI: assert property (sbi |=> {carry, acc} ==
    9'($past(op_imm)) + {1'b0, ~$past(acc)} + 9'($past(carry)) && !dmem_we)
    else $error("immediate subtract wrong");
  AST_AUXW: assert property (go && op_code == RSX_OP_AUX_WRITE |=>
    $stable(acc) && $stable(carry) && $stable(zero) && !dmem_we)
    else $error("aux write disturbed core state");
  AST_HALT: assert property (go && op_code == RSX_OP_HALT_ENTRY |=>
    halted && watchdog_expiry_flag && !powerdown_flag)
    else $error("halt entry state wrong");
endmodule

bind rsx_exec rsx_exec_checker u_rsx_exec_checker (
  .aclk, .aresetn, .op_valid, .op_code, .op_reg_addr, .op_dest, .op_imm,
  .dmem_rdata, .dmem_we, .dmem_waddr, .dmem_wdata, .op_done, .acc, .carry,
  .zero, .watchdog_expiry_flag, .powerdown_flag, .halted
);

// ===== verif/tb_rsx_exec.sv
`timescale 1ns/100ps

// ============================================================================
// self-checking bench for the execute unit
module tb_rsx_exec
  import rsx_pkg::*;
;
  // design ports
  logic        aclk, aresetn, op_valid, op_dest, dmem_we, op_done, halted;
  logic        carry, digit_carry, zero, watchdog_expiry_flag, powerdown_flag;
  rsx_op_t     op_code;
  logic [5:0]  op_reg_addr, dmem_waddr;
  logic [7:0]  op_imm, dmem_rdata, dmem_wdata, acc;
  logic [3:0]  op_aux_idx;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  // expected core state
  logic [7:0]  m_acc, m_aux [16];
  logic        m_c, m_dc, m_z, m_h;
  int          err_total, checks_done;

  rsx_exec u_rsx_exec (
    .aclk, .aresetn, .op_valid, .op_code, .op_reg_addr, .op_dest, .op_imm,
    .op_aux_idx, .dmem_rdata, .dmem_we, .dmem_waddr, .dmem_wdata, .op_done,
    .acc, .carry, .digit_carry, .zero, .watchdog_expiry_flag,
    .powerdown_flag, .halted, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );

  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // hang guard, well beyond the 2100-cycle watchdog wait
  initial begin
    #60000;
    err_total++;
    end_sim();
  end

  // ==========================================================================
  // shared tasks
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic axw(logic [11:0] a, logic [31:0] d, logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, r);
  endtask

  task automatic axr(logic [11:0] a, logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    chk("rresp", s_axi_rresp, r);
  endtask

  // one instruction; expectation worked out before it is issued
  task automatic op(rsx_op_t c, logic [7:0] r, logic d, logic [7:0] i,
                    logic [3:0] x);
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] v;
    logic       we, ok;
    s = {m_c, m_acc};
    we = 1'b0;
    ok = !m_h;
    if (ok) begin
      case (c)
        RSX_OP_ROT_RIGHT: begin
          s = {r[0], m_c, r[7:1]};
          we = d;
        end
        RSX_OP_SUB_BORROW_R, RSX_OP_SUB_BORROW_I: begin
          v = (c == RSX_OP_SUB_BORROW_R) ? r : i;
          we = d && c == RSX_OP_SUB_BORROW_R;
          s = v + {1'b0, ~m_acc} + m_c;
          n = v[3:0] + {1'b0, ~m_acc[3:0]} + m_c;
          m_dc = n[4];
          m_z = s[7:0] == 8'h00;
        end
        RSX_OP_AUX_READ: s[7:0] = m_aux[x];
        RSX_OP_AUX_WRITE: m_aux[x] = m_acc;
        RSX_OP_HALT_ENTRY: m_h = 1'b1;
        default: ;
      endcase
    end
    m_c = s[8];
    if (!we) m_acc = s[7:0];
    @(posedge aclk);
    op_valid <= 1'b1;
    op_code <= c;
    dmem_rdata <= r;
    op_dest <= d;
    op_imm <= i;
    op_aux_idx <= x;
    op_reg_addr <= {x, 2'b11};
    @(posedge aclk);
    op_valid <= 1'b0;
    #1;
    chk("done", op_done, ok);
    chk("acc", acc, m_acc);
    chk("flags", {carry, digit_carry, zero}, {m_c, m_dc, m_z});
    chk("we", dmem_we, we);
    if (we) chk("wb", {dmem_waddr, dmem_wdata}, {x, 2'b11, s[7:0]});
    chk("halted", halted, m_h);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    #1;
    chk("rst", {watchdog_expiry_flag, powerdown_flag, halted, op_done}, 4'hC);
    axr(OFS_WDT_CTRL, RESP_OKAY);
    chk("wdt ctrl", rd, 32'h0000_0700);
    axr(12'h010, RESP_SLVERR);
    axw(12'h010, 32'h0000_0001, RESP_SLVERR);
  endtask

  task automatic t_rot_sub;
    op(RSX_OP_ROT_RIGHT, 8'hA5, 1'b1, 8'h00, 4'h0);
    op(RSX_OP_ROT_RIGHT, 8'hA5, 1'b0, 8'h00, 4'hF);
    op(RSX_OP_ROT_RIGHT, 8'h40, 1'b0, 8'h00, 4'h3);
    op(RSX_OP_SUB_BORROW_I, 8'h00, 1'b1, 8'h05, 4'h0);
    op(RSX_OP_SUB_BORROW_R, 8'h05, 1'b1, 8'h00, 4'h7);
    op(RSX_OP_SUB_BORROW_R, 8'hF0, 1'b0, 8'h00, 4'hF);
    op(RSX_OP_SUB_BORROW_I, 8'h00, 1'b0, m_acc + 8'(!m_c), 4'h0);
    op(RSX_OP_NONE, 8'h00, 1'b1, 8'h00, 4'h1);
    op(rsx_op_t'(3'b111), 8'h00, 1'b1, 8'h00, 4'h2);
  endtask

  task automatic t_aux;
    for (int k = 0; k < 16; k++) begin
      op(RSX_OP_SUB_BORROW_I, 8'h00, 1'b0, 8'(k * 37), 4'(k));
      op(RSX_OP_AUX_WRITE, 8'h00, 1'b0, 8'h00, 4'(k));
    end
    for (int k = 15; k >= 0; k--)
      op(RSX_OP_AUX_READ, 8'h00, 1'b0, 8'h00, 4'(k));
  endtask

  // counter stopped before halt so a zero read proves the clear
  task automatic t_halt;
    axw(OFS_WDT_CTRL, 32'h0000_0001, RESP_OKAY);
    repeat (2100) @(posedge aclk);
    chk("expiry", watchdog_expiry_flag, 1'b0);
    axw(OFS_WDT_CTRL, 32'h0000_0000, RESP_OKAY);
    axr(OFS_WDT_CNT, RESP_OKAY);
    chk("cnt run", rd[15:0] != 16'h0000, 1'b1);
    op(RSX_OP_HALT_ENTRY, 8'h00, 1'b0, 8'h00, 4'h0);
    chk("to pd", {watchdog_expiry_flag, powerdown_flag}, 2'b10);
    axr(OFS_WDT_CNT, RESP_OKAY);
    chk("cnt", rd[15:0], 16'h0000);
    op(RSX_OP_SUB_BORROW_I, 8'h00, 1'b0, 8'h33, 4'h0);
    axw(OFS_WAKE, 32'h0000_0001, RESP_OKAY);
    m_h = 1'b0;
    axr(OFS_STATUS, RESP_OKAY);
    chk("st", rd[13:0], {3'b001, m_z, m_dc, m_c, m_acc});
  endtask

  // reset, then the scenarios in turn
  initial begin
    {op_valid, op_dest, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, aresetn} = '0;
    op_code = RSX_OP_NONE;
    {op_reg_addr, op_imm, dmem_rdata, op_aux_idx} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {m_acc, m_c, m_dc, m_z, m_h} = '0;
    m_aux = '{default: 8'h00};
    err_total = 0;
    checks_done = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_rot_sub();
    t_aux();
    t_halt();
    end_sim();
  end
endmodule
